// [core/nvs_pkg.sv]
package nvs_pkg;
    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int CMP_W  = 14;
    localparam int SEQ_LEN = 6;

    // ----------------------------------------------------------------
    // command sequence addresses
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] SEQ_A1      = 15'h0E38;
    localparam logic [ADDR_W-1:0] SEQ_A2      = 15'h31C7;
    localparam logic [ADDR_W-1:0] SEQ_A3      = 15'h03E0;
    localparam logic [ADDR_W-1:0] SEQ_A4      = 15'h3C1F;
    localparam logic [ADDR_W-1:0] SEQ_A5      = 15'h303F;
    localparam logic [ADDR_W-1:0] SEQ_STORE   = 15'h0FC0;
    localparam logic [ADDR_W-1:0] SEQ_RECALL  = 15'h0C63;
    localparam logic [ADDR_W-1:0] SEQ_AS_OFF  = 15'h0B45;
    localparam logic [ADDR_W-1:0] SEQ_AS_ON   = 15'h0B46;

    // ----------------------------------------------------------------
    // commands
    // ----------------------------------------------------------------
    localparam logic [2:0] CMD_STORE  = 3'h0;
    localparam logic [2:0] CMD_RECALL = 3'h1;
    localparam logic [2:0] CMD_AS_OFF = 3'h2;
    localparam logic [2:0] CMD_AS_ON  = 3'h3;
    localparam logic [2:0] CMD_READ   = 3'h4;
    localparam logic [2:0] CMD_WRITE  = 3'h5;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_NS       = 4;
    localparam int ACC_NS       = 25;
    localparam int ACC_CYC      = (ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_CYC      = 2;
    localparam int BUSY_DLY_CYC = 4;

    typedef enum logic [2:0] {
        NVS_IDLE  = 3'b000,
        NVS_SETUP = 3'b001,
        NVS_STROBE= 3'b011,
        NVS_GAP   = 3'b010,
        NVS_WAIT  = 3'b110,
        NVS_SETTLE= 3'b111
    } nvs_state_t;
endpackage : nvs_pkg

// [core/nvs_if.sv]
`timescale 1ns/1ns
`default_nettype none
// sequence address table shared between top and the lookup
interface nvs_seq_if;
    import nvs_pkg::*;
    logic [2:0]        step;
    logic [2:0]        cmd;
    logic [ADDR_W-1:0] addr;
    modport lookup (input step, input cmd, output addr);
    modport user   (output step, output cmd, input addr);
endinterface : nvs_seq_if
`default_nettype wire

// [core/nvs_seq_rom.sv]
`timescale 1ns/1ns
`default_nettype none
module nvs_seq_rom
    import nvs_pkg::*;
(
    nvs_seq_if.lookup sif
);
    // ----------------------------------------------------------------
    // address of each of the six reads
    // ----------------------------------------------------------------
    always_comb begin
        unique case (sif.step)
            3'h0: sif.addr = SEQ_A1;
            3'h1: sif.addr = SEQ_A2;
            3'h2: sif.addr = SEQ_A3;
            3'h3: sif.addr = SEQ_A4;
            3'h4: sif.addr = SEQ_A5;
            default: begin
                unique case (sif.cmd)
                    CMD_RECALL: sif.addr = SEQ_RECALL;
                    CMD_AS_OFF: sif.addr = SEQ_AS_OFF;
                    CMD_AS_ON:  sif.addr = SEQ_AS_ON;
                    default:    sif.addr = SEQ_STORE;
                endcase
            end
        endcase
    end
endmodule : nvs_seq_rom
`default_nettype wire

// [core/nvs_host.sv]
`timescale 1ns/1ns
`default_nettype none
module nvs_host
    import nvs_pkg::*;
#(
    parameter int ACC_CYCLES  = ACC_CYC,
    parameter int SETTLE_CYC  = BUSY_DLY_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              cmd_valid,
    input  wire logic [2:0]        cmd_op,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [DATA_W-1:0] cmd_wdata,
    output logic                   cmd_ready,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    output logic                   autosave_shadow,
    output logic                   store_pending,
    output logic                   ce_n,
    output logic                   oe_n,
    output logic                   we_n,
    output logic [ADDR_W-1:0]      addr,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe,
    input  wire logic [DATA_W-1:0] dq_in,
    input  wire logic              store_busy_n,
    input  wire logic              supply_ok
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic       busy_s1_reg, busy_s2_reg, sup_s1_reg, sup_s2_reg;
    // data bus is held through the whole strobe, so two stages only add latency
    logic [DATA_W-1:0] dq_s1_reg, dq_s2_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_s1_reg <= 1'b0;
            busy_s2_reg <= 1'b0;
            sup_s1_reg  <= 1'b0;
            sup_s2_reg  <= 1'b0;
            dq_s1_reg   <= '0;
            dq_s2_reg   <= '0;
        end else begin
            busy_s1_reg <= store_busy_n;
            busy_s2_reg <= busy_s1_reg;
            sup_s1_reg  <= supply_ok;
            sup_s2_reg  <= sup_s1_reg;
            dq_s1_reg   <= dq_in;
            dq_s2_reg   <= dq_s1_reg;
        end
    end
    // ----------------------------------------------------------------
    // sequence lookup
    // ----------------------------------------------------------------
    nvs_seq_if sif ();
    nvs_seq_rom u_rom (.sif(sif.lookup));

    nvs_state_t        state_reg, state_next;
    logic [2:0]        op_reg, op_next, step_reg, step_next;
    logic [7:0]        cnt_reg, cnt_next;
    logic [ADDR_W-1:0] a_reg, a_next;
    logic [DATA_W-1:0] wd_reg, wd_next, rd_reg, rd_next;
    logic              ce_reg, ce_next, oe_reg, oe_next, we_reg, we_next, dqe_reg, dqe_next;
    logic              rv_reg, rv_next, as_reg, as_next, sp_reg, sp_next, rdy_reg, rdy_next;
    logic              is_seq, can_go;

    assign sif.step = step_reg;
    assign sif.cmd  = op_reg;
    assign is_seq   = (op_reg == CMD_STORE) || (op_reg == CMD_RECALL) ||
                      (op_reg == CMD_AS_OFF) || (op_reg == CMD_AS_ON);
    // busy or low supply withholds cmd_ready in idle; an access already under way runs on
    assign can_go   = busy_s2_reg && sup_s2_reg;

    // ----------------------------------------------------------------
    // access sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        step_next = step_reg;
        cnt_next = cnt_reg;
        a_next = a_reg;
        wd_next = wd_reg;
        rd_next = rd_reg;
        ce_next = ce_reg;
        oe_next = oe_reg;
        we_next = we_reg;
        dqe_next = dqe_reg;
        rv_next = 1'b0;
        as_next = as_reg;
        sp_next = sp_reg;
        rdy_next = 1'b0;
        unique case (state_reg)
            NVS_IDLE: begin
                if (rdy_reg && cmd_valid) begin
                    op_next = cmd_op;
                    wd_next = cmd_wdata;
                    a_next = cmd_addr;
                    step_next = 3'h0;
                    state_next = NVS_SETUP;
                end else if (!can_go) begin
                    // supply return raises busy late; hold off past that gap
                    cnt_next = 8'(SETTLE_CYC);
                end else if (cnt_reg != 8'h00) begin
                    cnt_next = cnt_reg - 8'h01;
                end else begin
                    rdy_next = 1'b1;
                end
            end
            NVS_SETUP: begin
                // sequence steps never interleave with other traffic
                if (is_seq) begin
                    // top bit zero; device ignores it anyway
                    a_next = {1'b0, sif.addr[CMP_W-1:0]};
                end
                ce_next = 1'b0;
                we_next = !(op_reg == CMD_WRITE);
                oe_next = (op_reg == CMD_WRITE);
                dqe_next = (op_reg == CMD_WRITE);
                cnt_next = 8'(ACC_CYCLES);
                state_next = NVS_STROBE;
            end
            NVS_STROBE: begin
                if (cnt_reg != 8'h00) begin
                    cnt_next = cnt_reg - 8'h01;
                end else begin
                    rd_next = dq_s2_reg;
                    ce_next = 1'b1;
                    oe_next = 1'b1;
                    we_next = 1'b1;
                    dqe_next = 1'b0;
                    cnt_next = 8'(GAP_CYC);
                    state_next = NVS_GAP;
                end
            end
            NVS_GAP: begin
                if (cnt_reg != 8'h00) begin
                    cnt_next = cnt_reg - 8'h01;
                end else if (is_seq && step_reg != 3'(SEQ_LEN - 1)) begin
                    step_next = step_reg + 3'h1;
                    state_next = NVS_SETUP;
                end else if (op_reg == CMD_STORE || op_reg == CMD_RECALL) begin
                    cnt_next = 8'(SETTLE_CYC);
                    state_next = NVS_WAIT;
                end else begin
                    if (op_reg == CMD_AS_OFF) begin
                        as_next = 1'b0;
                        sp_next = 1'b1;
                    end
                    if (op_reg == CMD_AS_ON) begin
                        as_next = 1'b1;
                        sp_next = 1'b1;
                    end
                    rv_next = 1'b1;
                    state_next = NVS_IDLE;
                end
            end
            NVS_WAIT: begin
                // let busy reach the synchroniser before trusting it
                if (cnt_reg != 8'h00) begin
                    cnt_next = cnt_reg - 8'h01;
                end else if (busy_s2_reg) begin
                    cnt_next = 8'(SETTLE_CYC);
                    state_next = NVS_SETTLE;
                end
            end
            NVS_SETTLE: begin
                if (!busy_s2_reg) begin
                    cnt_next = 8'(SETTLE_CYC);
                end else if (cnt_reg != 8'h00) begin
                    cnt_next = cnt_reg - 8'h01;
                end else begin
                    if (op_reg == CMD_STORE) begin
                        sp_next = 1'b0;
                    end
                    rv_next = 1'b1;
                    state_next = NVS_IDLE;
                end
            end
            default: state_next = NVS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= NVS_IDLE;
            op_reg <= CMD_READ;
            step_reg <= 3'h0;
            cnt_reg <= 8'h00;
            a_reg <= '0;
            wd_reg <= '0;
            rd_reg <= '0;
            ce_reg <= 1'b1;
            oe_reg <= 1'b1;
            we_reg <= 1'b1;
            dqe_reg <= 1'b0;
            rv_reg <= 1'b0;
            as_reg <= 1'b1;
            sp_reg <= 1'b0;
            rdy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            step_reg <= step_next;
            cnt_reg <= cnt_next;
            a_reg <= a_next;
            wd_reg <= wd_next;
            rd_reg <= rd_next;
            ce_reg <= ce_next;
            oe_reg <= oe_next;
            we_reg <= we_next;
            dqe_reg <= dqe_next;
            rv_reg <= rv_next;
            as_reg <= as_next;
            sp_reg <= sp_next;
            rdy_reg <= rdy_next;
        end
    end

    assign cmd_ready = rdy_reg;
    assign rsp_valid = rv_reg;
    assign rsp_rdata = rd_reg;
    assign autosave_shadow = as_reg;
    assign store_pending = sp_reg;
    assign ce_n = ce_reg;
    assign oe_n = oe_reg;
    assign we_n = we_reg;
    assign addr = a_reg;
    assign dq_out = wd_reg;
    assign dq_oe = dqe_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_we_high_seq: assert property (@(posedge clk) disable iff (rst)
        (is_seq && state_reg != NVS_IDLE) |-> we_reg) else $error("write enable low in sequence");
    a_top_bit_zero: assert property (@(posedge clk) disable iff (rst)
        (is_seq && !ce_reg) |-> !a_reg[ADDR_W-1]) else $error("sequence top address bit set");
    a_first_addr: assert property (@(posedge clk) disable iff (rst)
        (is_seq && step_reg == 3'h0 && !ce_reg) |-> a_reg == SEQ_A1) else $error("wrong first address");
    a_fifth_addr: assert property (@(posedge clk) disable iff (rst)
        (is_seq && step_reg == 3'h4 && !ce_reg) |-> a_reg == SEQ_A5) else $error("wrong fifth address");
    a_store_addr: assert property (@(posedge clk) disable iff (rst)
        (op_reg == CMD_STORE && step_reg == 3'h5 && !ce_reg) |-> a_reg == SEQ_STORE)
        else $error("wrong store address");
    a_busy_blocks: assert property (@(posedge clk) disable iff (rst)
        (!can_go && state_reg == NVS_IDLE) |=> !rdy_reg) else $error("ready while busy");
    a_as_off: assert property (@(posedge clk) disable iff (rst)
        (state_reg == NVS_GAP && state_next == NVS_IDLE && op_reg == CMD_AS_OFF) |=> !as_reg && sp_reg)
        else $error("autosave not cleared");
    a_as_on: assert property (@(posedge clk) disable iff (rst)
        (state_reg == NVS_GAP && state_next == NVS_IDLE && op_reg == CMD_AS_ON) |=> as_reg && sp_reg)
        else $error("autosave not set");
    a_ready_holdoff: assert property (@(posedge clk) disable iff (rst)
        (state_reg == NVS_IDLE && !can_go) |=> !rdy_reg [*5]) else $error("ready inside hold-off");
    a_settle_busy: assert property (@(posedge clk) disable iff (rst)
        (state_reg == NVS_SETTLE && !busy_s2_reg) |=> state_reg == NVS_SETTLE)
        else $error("left settle while busy");
    c_store: cover property (@(posedge clk) disable iff (rst)
        state_reg == NVS_SETTLE && op_reg == CMD_STORE && rv_next);
    c_recall: cover property (@(posedge clk) disable iff (rst)
        state_reg == NVS_SETTLE && op_reg == CMD_RECALL && rv_next);
    c_as_off: cover property (@(posedge clk) disable iff (rst) op_reg == CMD_AS_OFF && rv_reg);
    c_write: cover property (@(posedge clk) disable iff (rst) op_reg == CMD_WRITE && rv_reg);
endmodule : nvs_host
`default_nettype wire

// [tb/nvs_dev_model.sv]
`timescale 1ns/1ns
`default_nettype none
module nvs_dev_model
    import nvs_pkg::*;
#(
    parameter int STORE_CYC  = 200,
    parameter int RECALL_CYC = 100,
    parameter int PUR_CYC    = 150,
    parameter int DLY_CYC    = 4
) (
    input  wire logic              clk,
    input  wire logic              ce_n,
    input  wire logic              oe_n,
    input  wire logic              we_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] dq_out,
    input  wire logic              dq_oe,
    input  wire logic              supply_ok,
    output logic [DATA_W-1:0]      dq_in,
    output logic                   store_busy_n
);
    // ----------------------------------------------------------------
    // array, shadow cells, sequence state
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] mem [0:32767];
    logic [DATA_W-1:0] nv  [0:32767];
    logic [ADDR_W-1:0] seq [0:4];
    logic              autosave_en = 1'b1;
    logic              nv_as       = 1'b1;
    logic              pend        = 1'b1;
    logic              rd_q        = 1'b0;
    logic              wr_q        = 1'b0;
    logic              sup_q       = 1'b0;
    logic [ADDR_W-1:0] a_q;
    logic [DATA_W-1:0] d_q;
    int                step = 0;
    int                bcnt = 0;
    int                cool = 0;
    logic              rd;
    logic              wr;
    logic              hz;
    logic              idle;
    initial begin
        foreach (nv[i]) nv[i] = 8'h00;
        mem = nv;
        seq = '{SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4, SEQ_A5};
        dq_in = 8'h00;
        store_busy_n = 1'b1;
    end
    assign rd   = !ce_n && !oe_n && we_n;
    assign wr   = !ce_n && !we_n;
    assign hz   = step == 5 && (addr[13:0] == SEQ_STORE[13:0] || addr[13:0] == SEQ_RECALL[13:0]);
    assign idle = supply_ok && bcnt == 0 && cool == 0;
    task automatic seq_step(input logic [ADDR_W-1:0] a);
        if (step < 5) begin
            // only the low 14 lines take part in the match
            if (a[13:0] == seq[step][13:0]) step++;
            else step = (a[13:0] == SEQ_A1[13:0]) ? 1 : 0;
        end else begin
            step = 0;
            if (supply_ok && a[13:0] == SEQ_STORE[13:0]) begin
                nv = mem;
                nv_as = autosave_en;
                bcnt = STORE_CYC;
            end
            if (a[13:0] == SEQ_RECALL[13:0]) begin
                mem = nv;
                bcnt = RECALL_CYC;
            end
            if (a[13:0] == SEQ_AS_OFF[13:0]) autosave_en = 1'b0;
            if (a[13:0] == SEQ_AS_ON[13:0]) autosave_en = 1'b1;
        end
    endtask
    always @(posedge clk) begin
        // released bus toggles every cycle, showing the last byte and its inverse in turn
        if (rd && idle && !hz) dq_in <= mem[addr];
        else dq_in <= ~dq_in;
        if (rd || wr) a_q = addr;
        if (wr) d_q = dq_oe ? dq_out : ~dq_out;
        if (rd_q && !rd && idle) seq_step(a_q);
        if (wr_q && !wr) begin
            step = 0;
            if (idle) mem[a_q] = d_q;
        end
        if (!supply_ok) begin
            if (sup_q && autosave_en) nv = mem;
            pend = 1'b1;
        end else if (pend && bcnt == 0) begin
            pend = 1'b0;
            mem = nv;
            autosave_en = nv_as;
            bcnt = PUR_CYC;
        end
        if (bcnt > 0) begin
            bcnt--;
            if (bcnt == 0) cool = DLY_CYC;
        end else if (cool > 0) cool--;
        rd_q = rd;
        wr_q = wr;
        sup_q = supply_ok;
        // registered so the host never samples it in the edge that moves it
        store_busy_n <= (bcnt == 0);
    end
endmodule // nvs_dev_model
`default_nettype wire

// [tb/tb_nvs_host.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_nvs_host;
    import nvs_pkg::*;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              cmd_valid = 1'b0;
    logic [2:0]        cmd_op = 3'h4;
    logic [ADDR_W-1:0] cmd_addr = 15'h0000;
    logic [DATA_W-1:0] cmd_wdata = 8'h00;
    logic              supply_ok = 1'b0;
    logic              cmd_ready, rsp_valid, autosave_shadow, store_pending;
    logic              ce_n, oe_n, we_n, dq_oe, store_busy_n;
    logic [DATA_W-1:0] rsp_rdata, dq_out, dq_in;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] adr [0:7];
    int                failures = 0;
    int                check_count = 0;
    int                seed = 47311;
    int                ref_mem [int];
    int                ref_nv [int];
    int                ref_as = 1;
    int                ref_nv_as = 1;
    initial begin
        forever #2 clk = ~clk;
    end
    nvs_host dut_u (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .autosave_shadow(autosave_shadow), .store_pending(store_pending), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
        .store_busy_n(store_busy_n), .supply_ok(supply_ok));
    nvs_dev_model dev_u (.clk(clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_out(dq_out),
        .dq_oe(dq_oe), .supply_ok(supply_ok), .dq_in(dq_in), .store_busy_n(store_busy_n));
    // ----------------------------------------------------------------
    // checking and bus tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic timeout();
        chk(8'h00, 8'h01);
        give_verdict();
    endtask
    task automatic do_cmd(input logic [2:0] op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        for (n = 0; n < 5000 && cmd_ready !== 1'b1; n++) @(negedge clk);
        if (n == 5000) timeout();
        @(negedge clk);
        cmd_valid = 1'b0;
        for (n = 0; n < 5000 && rsp_valid !== 1'b1; n++) @(negedge clk);
        if (n == 5000) timeout();
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        do_cmd(CMD_WRITE, a, d);
        ref_mem[a] = d;
    endtask
    task automatic rd_chk(input logic [ADDR_W-1:0] a);
        do_cmd(CMD_READ, a, 8'h00);
        chk(rsp_rdata, ref_mem.exists(a) ? 8'(ref_mem[a]) : 8'h00);
    endtask
    task automatic store();
        do_cmd(CMD_STORE, 15'h0000, 8'h00);
        ref_nv = ref_mem;
        ref_nv_as = ref_as;
    endtask
    // drop below threshold, then come back with the power-up recall
    task automatic power_cycle();
        int n;
        @(negedge clk);
        supply_ok = 1'b0;
        if (ref_as != 0) ref_nv = ref_mem;
        repeat (8) @(negedge clk);
        chk(8'(cmd_ready), 8'h00);
        supply_ok = 1'b1;
        ref_mem = ref_nv;
        ref_as = ref_nv_as;
        for (n = 0; n < 50 && store_busy_n !== 1'b0; n++) @(negedge clk);
        chk(8'(store_busy_n), 8'h00);
        repeat (3) @(negedge clk);
        chk(8'(cmd_ready), 8'h00);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        int i;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        chk(8'(autosave_shadow), 8'h01);
        power_cycle();
        for (i = 0; i < 8; i++) begin
            adr[i] = 15'($random(seed));
            wr(adr[i], 8'($random(seed)));
        end
        for (i = 0; i < 8; i++) rd_chk(adr[i]);
        store();
        chk(dev_u.nv[adr[0]], 8'(ref_nv[adr[0]]));
        wr(adr[0], 8'hA5);
        wr(adr[1], 8'h3C);
        do_cmd(CMD_RECALL, 15'h0000, 8'h00);
        ref_mem = ref_nv;
        rd_chk(adr[0]);
        rd_chk(adr[1]);
        chk(dev_u.nv[adr[1]], 8'(ref_nv[adr[1]]));
        do_cmd(CMD_AS_OFF, 15'h0000, 8'h00);
        ref_as = 0;
        chk(8'(autosave_shadow), 8'h00);
        chk(8'(dev_u.autosave_en), 8'h00);
        chk(8'(store_pending), 8'h01);
        store();
        chk(8'(store_pending), 8'h00);
        wr(adr[2], 8'hC3);
        power_cycle();
        rd_chk(adr[2]);
        chk(8'(dev_u.autosave_en), 8'h00);
        do_cmd(CMD_AS_ON, 15'h0000, 8'h00);
        ref_as = 1;
        chk(8'(autosave_shadow), 8'h01);
        chk(8'(dev_u.autosave_en), 8'h01);
        store();
        wr(adr[3], 8'h96);
        power_cycle();
        rd_chk(adr[3]);
        give_verdict();
    end
endmodule // tb_nvs_host
`default_nettype wire
